// [hw/cpumap_pkg.sv]
package cpumap_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 16;

    // memory map windows
    localparam logic [15:0] MAP_RSV_LO    = 16'h0000;
    localparam logic [15:0] MAP_RSV_HI    = 16'h04A2;
    localparam logic [15:0] MAP_IRAM_HI   = 16'h3FFF;
    localparam logic [15:0] MAP_XRAM_LO   = 16'h4000;
    localparam logic [15:0] MAP_XRAM_HI   = 16'hBFFF;
    localparam logic [15:0] MAP_CREG_LO   = 16'hC000;
    localparam logic [15:0] MAP_CREG_HI   = 16'hC0FF;
    localparam logic [15:0] MAP_XROM_LO   = 16'hC100;
    localparam logic [15:0] MAP_XROM_HI   = 16'hDFFF;
    localparam logic [15:0] MAP_BROM_LO   = 16'hE000;

    // control register byte offsets
    localparam logic [15:0] OFS_FLAGS     = 16'hC000;
    localparam logic [15:0] OFS_BANK      = 16'hC002;
    localparam logic [15:0] OFS_REV       = 16'hC004;
    localparam logic [15:0] OFS_CLKDIV    = 16'hC008;
    localparam logic [15:0] OFS_PWR       = 16'hC00A;
    localparam logic [15:0] OFS_IRQEN     = 16'hC00E;
    localparam logic [15:0] OFS_BRKPT     = 16'hC014;
    localparam logic [15:0] OFS_USBDIAG   = 16'hC03C;
    localparam logic [15:0] OFS_MEMDIAG   = 16'hC03E;
    localparam logic [15:0] OFS_XPAGE     = 16'hC040;

    // field layouts and reset values
    localparam int unsigned FLG_GIE       = 4;
    localparam int unsigned FLG_NEG       = 3;
    localparam int unsigned FLG_OVF       = 2;
    localparam int unsigned FLG_CRY       = 1;
    localparam int unsigned FLG_ZER       = 0;
    localparam logic [15:0] BANK_MASK     = 16'hFFF0;
    localparam logic [15:0] BANK_RESET    = 16'h0100;
    localparam logic [15:0] CLKDIV_MASK   = 16'h000F;
    localparam logic [15:0] CLKDIV_RESET  = 16'h000F;
    localparam logic [15:0] PWR_MASK      = 16'hFB93;
    localparam int unsigned PWR_BOOST_BIT = 2;
    localparam logic [15:0] ZERO_RESET    = 16'h0000;
    localparam int unsigned XPAGE_W       = 3;
    localparam int unsigned XADDR_W       = 19;

    typedef struct packed {
        logic        gie;
        logic        neg;
        logic        ovf;
        logic        cry;
        logic        zer;
    } cpumap_flags_t;

    typedef struct packed {
        logic        ram;
        logic        rom;
        logic        creg;
        logic        brom;
        logic        iram;
        logic        rsv;
    } cpumap_region_t;

endpackage

// [hw/cpumap_regs.sv]
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
module cpumap_regs
    import cpumap_pkg::*;
#(
    parameter logic [15:0] SILICON_REV = 16'h0A5A  // arbitrary value
) (
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    // classic wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [31:0]           wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    output logic                       wb_err_o,
    // cpu side
    input  wire cpumap_pkg::cpumap_flags_t cpu_flags,
    input  wire logic                  usb_host_mode,
    input  wire logic [cpumap_pkg::ADDR_W-1:0] cpu_addr,
    input  wire logic                  cpu_req,
    input  wire logic [3:0]            gpr_num,
    output logic [cpumap_pkg::ADDR_W-1:0] gpr_addr,
    output cpumap_pkg::cpumap_region_t region,
    output logic                       ext_ram_select_n,
    output logic                       ext_rom_select_n,
    output logic [cpumap_pkg::XADDR_W-1:0] ext_addr,
    output logic [3:0]                 clk_divisor,
    output logic                       sleep_request,
    output logic                       halt_request,
    output logic [15:0]                irq_enable,
    output logic [15:0]                breakpoint,
    output logic [15:0]                usb_diag,
    output logic [15:0]                mem_diag,
    input  wire logic                  boost_not_ok
);
    import cpumap_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0]        bank_reg;
    logic [15:0]        clkdiv_reg;
    logic [15:0]        pwr_reg;
    logic [15:0]        irqen_reg;
    logic [15:0]        brkpt_reg;
    logic [15:0]        usbdiag_reg;
    logic [15:0]        memdiag_reg;
    logic [15:0]        usbdiag_host_reg;
    logic [XPAGE_W-1:0] xpage_reg;
    logic               ack_reg;
    logic               err_reg;
    logic [31:0]        rdat_reg;
    logic [ADDR_W-1:0]  gpr_addr_reg;
    cpumap_region_t     region_next;
    cpumap_region_t     region_reg;
    logic [XADDR_W-1:0] ext_addr_reg;

    ////////////////////////////////////////////////////////////////////////
    // wishbone decode
    logic        req;
    logic [15:0] badr;
    logic [15:0] wdat;
    logic        hit;
    logic        wr;
    logic        lanes_ok;
    logic [15:0] rd_next;

    assign req      = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
    assign badr     = wb_adr_i[15:0];
    assign wdat     = wb_dat_i[15:0];
    assign lanes_ok = (wb_sel_i[1:0] == 2'h3);
    assign wr       = req && hit && wb_we_i && lanes_ok;

    always_comb begin
        hit     = 1'b1;
        rd_next = 16'h0000;
        unique case (badr)
            OFS_FLAGS: begin
                rd_next = {11'h000, cpu_flags.gie, cpu_flags.neg,
                           cpu_flags.ovf, cpu_flags.cry, cpu_flags.zer};
            end
            OFS_BANK:    rd_next = bank_reg;
            OFS_REV:     rd_next = SILICON_REV;
            OFS_CLKDIV:  rd_next = clkdiv_reg;
            OFS_PWR: begin
                rd_next = pwr_reg;
                rd_next[PWR_BOOST_BIT] = boost_not_ok;
            end
            OFS_IRQEN:   rd_next = irqen_reg;
            OFS_BRKPT:   rd_next = brkpt_reg;
            OFS_USBDIAG: rd_next = 16'h0000;
            OFS_MEMDIAG: rd_next = 16'h0000;
            OFS_XPAGE:   rd_next = {13'h0000, xpage_reg};
            default:     hit = 1'b0;
        endcase
        if (wb_adr_i[31:16] != 16'h0000 || badr[0]) begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ack_reg  <= 1'b0;
            err_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg  <= req && hit;
            err_reg  <= req && !hit;
            rdat_reg <= (req && hit && !wb_we_i) ? {16'h0000, rd_next} : 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;
    assign wb_dat_o = rdat_reg;

    ////////////////////////////////////////////////////////////////////////
    // writable registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bank_reg         <= BANK_RESET;
            clkdiv_reg       <= CLKDIV_RESET;
            pwr_reg          <= ZERO_RESET;
            irqen_reg        <= ZERO_RESET;
            brkpt_reg        <= ZERO_RESET;
            usbdiag_reg      <= ZERO_RESET;
            usbdiag_host_reg <= ZERO_RESET;
            memdiag_reg      <= ZERO_RESET;
            xpage_reg        <= '0;
        end else if (wr) begin
            unique case (badr)
                OFS_BANK:    bank_reg   <= wdat & BANK_MASK;
                OFS_CLKDIV:  clkdiv_reg <= wdat & CLKDIV_MASK;
                OFS_PWR:     pwr_reg    <= wdat & PWR_MASK;
                OFS_IRQEN:   irqen_reg  <= wdat;
                OFS_BRKPT:   brkpt_reg  <= wdat;
                OFS_USBDIAG: begin
                    if (usb_host_mode) begin
                        usbdiag_host_reg <= wdat;
                    end else begin
                        usbdiag_reg <= wdat;
                    end
                end
                OFS_MEMDIAG: memdiag_reg <= wdat;
                OFS_XPAGE:   xpage_reg   <= wdat[XPAGE_W-1:0];
                default: begin
                end
            endcase
        end
    end

    assign clk_divisor   = clkdiv_reg[3:0];
    assign sleep_request = pwr_reg[1];
    assign halt_request  = pwr_reg[0];
    assign irq_enable    = irqen_reg;
    assign breakpoint    = brkpt_reg;
    assign usb_diag      = usb_host_mode ? usbdiag_host_reg : usbdiag_reg;
    assign mem_diag      = memdiag_reg;

    ////////////////////////////////////////////////////////////////////////
    // general register address
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            gpr_addr_reg <= BANK_RESET;
        end else begin
            gpr_addr_reg <= (bank_reg | {11'h000, gpr_num, 1'b0}) & 16'hFFFE;
        end
    end

    assign gpr_addr = gpr_addr_reg;

    ////////////////////////////////////////////////////////////////////////
    // memory map decode, one cycle after cpu_addr
    always_comb begin
        region_next      = '0;
        region_next.rsv  = (cpu_addr <= MAP_RSV_HI);
        region_next.iram = (cpu_addr <= MAP_IRAM_HI);
        region_next.ram  = (cpu_addr >= MAP_XRAM_LO) && (cpu_addr <= MAP_XRAM_HI);
        region_next.creg = (cpu_addr >= MAP_CREG_LO) && (cpu_addr <= MAP_CREG_HI);
        region_next.rom  = (cpu_addr >= MAP_XROM_LO) && (cpu_addr <= MAP_XROM_HI);
        region_next.brom = (cpu_addr >= MAP_BROM_LO);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            region_reg   <= '0;
            ext_addr_reg <= '0;
        end else begin
            region_reg   <= cpu_req ? region_next : '0;
            ext_addr_reg <= {xpage_reg, cpu_addr};
        end
    end

    assign region           = region_reg;
    assign ext_ram_select_n = !region_reg.ram;
    assign ext_rom_select_n = !region_reg.rom;
    assign ext_addr         = ext_addr_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_bank_reset;
        @(posedge sys_clk) reset |=> (bank_reg == BANK_RESET);
    endproperty
    a_bank_reset: assert property (p_bank_reset) else $error("bank reset value wrong");

    property p_ram_sel;
        @(posedge sys_clk) disable iff (reset)
        (cpu_req && cpu_addr >= MAP_XRAM_LO && cpu_addr <= MAP_XRAM_HI) |=> !ext_ram_select_n;
    endproperty
    a_ram_sel: assert property (p_ram_sel) else $error("ram select missing");

    property p_rom_sel;
        @(posedge sys_clk) disable iff (reset)
        (cpu_req && cpu_addr >= MAP_XROM_LO && cpu_addr <= MAP_XROM_HI) |=> !ext_rom_select_n;
    endproperty
    a_rom_sel: assert property (p_rom_sel) else $error("rom select missing");

    property p_int_no_sel;
        @(posedge sys_clk) disable iff (reset)
        (cpu_addr < MAP_XRAM_LO || cpu_addr >= MAP_CREG_LO && cpu_addr <= MAP_CREG_HI
         || cpu_addr >= MAP_BROM_LO) |=> (ext_ram_select_n && ext_rom_select_n);
    endproperty
    a_int_no_sel: assert property (p_int_no_sel) else $error("select on internal");

    property p_gpr;
        @(posedge sys_clk) disable iff (reset)
        1'b1 |=> (gpr_addr == ($past(bank_reg) | {11'h000, $past(gpr_num), 1'b0}));
    endproperty
    a_gpr: assert property (p_gpr) else $error("gpr address wrong");

    sequence s_wr_bank;
        wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == {16'h0000, OFS_BANK}
        && wb_sel_i == 4'hF;
    endsequence
    property p_bank_wr;
        @(posedge sys_clk) disable iff (reset)
        s_wr_bank |=> (bank_reg == ($past(wb_dat_i[15:0]) & BANK_MASK));
    endproperty
    a_bank_wr: assert property (p_bank_wr) else $error("bank write wrong");

    property p_rev;
        @(posedge sys_clk) disable iff (reset)
        (req && !wb_we_i && badr == OFS_REV) |=> (wb_ack_o && wb_dat_o[15:0] == SILICON_REV);
    endproperty
    a_rev: assert property (p_rev) else $error("revision read wrong");

    property p_flags;
        @(posedge sys_clk) disable iff (reset)
        (req && !wb_we_i && badr == OFS_FLAGS) |=> (wb_dat_o[FLG_GIE] == $past(cpu_flags.gie)
        && wb_dat_o[FLG_ZER] == $past(cpu_flags.zer) && wb_dat_o[15:5] == 11'h000);
    endproperty
    a_flags: assert property (p_flags) else $error("flags read wrong");

    property p_ack_drop;
        @(posedge sys_clk) disable iff (reset) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack held");

endmodule

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
    import cpumap_pkg::*;
    localparam logic [15:0] REV = 16'h0A5A;  // arbitrary value
    typedef struct packed {
        logic [15:0] adr;
        logic [15:0] wd;
        logic [15:0] exp;
        logic [4:0]  flg;
    } cpumap_row_t;
    logic                 sys_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [31:0]          wb_adr_i, wb_dat_i, wb_dat_o;
    logic [3:0]           wb_sel_i, gpr_num, clk_divisor;
    logic                 wb_ack_o, wb_err_o, usb_host_mode, cpu_req, boost_not_ok;
    logic                 ext_ram_select_n, ext_rom_select_n, sleep_request, halt_request;
    cpumap_flags_t        cpu_flags;
    cpumap_region_t       region;
    logic [15:0]          cpu_addr, gpr_addr, irq_enable, breakpoint, usb_diag, mem_diag;
    logic [XADDR_W-1:0]   ext_addr;
    logic [15:0]          q;
    logic                 e;
    int                   fails, comparisons;
    cpumap_row_t          rows [11];
    cpumap_regs #(.SILICON_REV(REV)) i_cpumap_regs (.sys_clk(sys_clk), .reset(reset),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .cpu_flags(cpu_flags), .usb_host_mode(usb_host_mode),
        .cpu_addr(cpu_addr), .cpu_req(cpu_req), .gpr_num(gpr_num), .gpr_addr(gpr_addr),
        .region(region), .ext_ram_select_n(ext_ram_select_n),
        .ext_rom_select_n(ext_rom_select_n), .ext_addr(ext_addr),
        .clk_divisor(clk_divisor), .sleep_request(sleep_request),
        .halt_request(halt_request), .irq_enable(irq_enable), .breakpoint(breakpoint),
        .usb_diag(usb_diag), .mem_diag(mem_diag), .boost_not_ok(boost_not_ok));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one classic cycle, held until ack or err is sampled high
    task automatic wb(input logic we, input logic [15:0] a, input logic [15:0] d,
                      input logic [3:0] sel, output logic [15:0] rd, output logic er);
        int n;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {16'h0000, a};
        wb_dat_i <= {16'h0000, d};
        wb_sel_i <= sel;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            print_verdict();
        end
        rd = wb_dat_o[15:0];
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // cpu access, checked one edge after it is presented
    task automatic map(input logic [15:0] a, input logic [3:0] exp_reg, input logic [1:0] sel_n);
        @(posedge sys_clk);
        cpu_addr <= a;
        cpu_req  <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk("selects", {30'h0, sel_n}, {30'h0, ext_ram_select_n, ext_rom_select_n});
        chk("region", {28'h0, exp_reg}, {28'h0, region.ram, region.rom, region.creg,
            region.brom});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, cpu_req, usb_host_mode} = 5'h00;
        wb_adr_i = 32'h0000_0000;
        wb_dat_i = 32'h0000_0000;
        wb_sel_i = 4'hF;
        cpu_flags = cpumap_flags_t'(5'h16);
        cpu_addr = 16'h0000;
        gpr_num = 4'hE;
        boost_not_ok = 1'b1;
        fails = 0;
        comparisons = 0;
        rows = '{'{16'hC000, 16'hFFFF, 16'h0016, 5'h16}, '{16'hC000, 16'h0000, 16'h0009, 5'h09},
                 '{16'hC002, 16'hFFFF, 16'hFFF0, 5'h16}, '{16'hC004, 16'h0000, REV, 5'h16},
                 '{16'hC008, 16'hFFFF, 16'h000F, 5'h16}, '{16'hC008, 16'h0003, 16'h0003, 5'h16},
                 '{16'hC00A, 16'hFFFF, 16'hFB97, 5'h16}, '{16'hC00A, 16'h0003, 16'h0007, 5'h16},
                 '{16'hC00E, 16'hA5A5, 16'hA5A5, 5'h16}, '{16'hC014, 16'h1234, 16'h1234, 5'h16},
                 '{16'hC03E, 16'h3333, 16'h0000, 5'h16}};
        reset = 1'b1;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("gpr_addr_reset", 32'h0000_011C, {16'h0, gpr_addr});
        wb(1'b0, 16'hC002, 16'h0000, 4'hF, q, e);
        chk("bank_reset", 32'h0000_0100, {16'h0, q});
        for (int i = 0; i < 11; i++) begin
            cpu_flags <= cpumap_flags_t'(rows[i].flg);
            wb(1'b1, rows[i].adr, rows[i].wd, 4'hF, q, e);
            wb(1'b0, rows[i].adr, 16'h0000, 4'hF, q, e);
            chk("reg_read", {16'h0, rows[i].exp}, {16'h0, q});
        end
        #1;
        chk("gpr_addr", 32'h0000_FFFC, {16'h0, gpr_addr});
        chk("outputs", {4'h3, 2'b11, 10'h0, 16'hA5A5},
            {clk_divisor, sleep_request, halt_request, 10'h0, irq_enable});
        chk("bkpt_mem", {16'h1234, 16'h3333}, {breakpoint, mem_diag});
        gpr_num <= 4'h3;
        @(posedge sys_clk);
        #1;
        chk("gpr_addr_r3", 32'h0000_FFF6, {16'h0, gpr_addr});
        wb(1'b1, 16'hC00E, 16'h0F0F, 4'h1, q, e);
        #1;
        chk("sel_ignored", 32'h0000_A5A5, {16'h0, irq_enable});
        wb(1'b0, 16'hC006, 16'h0000, 4'hF, q, e);
        chk("err_unmapped", 32'h1, {31'h0, e});
        wb(1'b0, 16'hC003, 16'h0000, 4'hF, q, e);
        chk("err_odd", 32'h1, {31'h0, e});
        usb_host_mode <= 1'b0;
        wb(1'b1, 16'hC03C, 16'h1111, 4'hF, q, e);
        usb_host_mode <= 1'b1;
        wb(1'b1, 16'hC03C, 16'h2222, 4'hF, q, e);
        #1;
        chk("usb_diag_host", 32'h0000_2222, {16'h0, usb_diag});
        usb_host_mode <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("usb_diag_dev", 32'h0000_1111, {16'h0, usb_diag});
        wb(1'b0, 16'hC03C, 16'h0000, 4'hF, q, e);
        chk("usb_diag_read", 32'h0, {16'h0, q});
        map(16'h0000, 4'h0, 2'b11);
        chk("low_region", 32'h3, {30'h0, region.iram, region.rsv});
        map(16'h04A3, 4'h0, 2'b11);
        chk("rsv_edge", 32'h2, {30'h0, region.iram, region.rsv});
        map(16'h3FFF, 4'h0, 2'b11);
        chk("iram_top", 32'h2, {30'h0, region.iram, region.rsv});
        map(16'h4000, 4'h8, 2'b01);
        map(16'hBFFF, 4'h8, 2'b01);
        map(16'hC000, 4'h2, 2'b11);
        map(16'hC0FF, 4'h2, 2'b11);
        map(16'hC100, 4'h4, 2'b10);
        map(16'hDFFF, 4'h4, 2'b10);
        map(16'hE000, 4'h1, 2'b11);
        map(16'hFFFF, 4'h1, 2'b11);
        wb(1'b1, 16'hC040, 16'h0005, 4'hF, q, e);
        map(16'h4123, 4'h8, 2'b01);
        chk("ext_addr", {13'h0, 19'h54123}, {13'h0, ext_addr});
        cpu_req <= 1'b0;
        @(posedge sys_clk);
        @(posedge sys_clk);
        #1;
        chk("region_idle", 32'h0, {26'h0, region});
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("reset_outs", {4'hF, 2'b00, 10'h0, 16'h0000},
            {clk_divisor, sleep_request, halt_request, 10'h0, irq_enable});
        wb(1'b0, 16'hC002, 16'h0000, 4'hF, q, e);
        chk("bank_rereset", 32'h0000_0100, {16'h0, q});
        wb(1'b0, 16'hC008, 16'h0000, 4'hF, q, e);
        chk("clkdiv_rereset", 32'h0000_000F, {16'h0, q});
        print_verdict();
    end
endmodule
